// File: core/usb_host_ctrl_pkg.sv
// Package: register map, field positions and reset values of the host
// control and target address registers.
// Assumes a 32-bit APB slave with one aligned word per register.
package usb_host_ctrl_pkg;
	localparam logic [11:0] host_control_offset = 12'h000;
	localparam logic [11:0] target_address_offset = 12'h004;

	localparam int reg_width = 16;
	localparam int addr_width = 12;

	// Host control register field positions
	localparam int frame_start_enable_bit = 0;
	localparam int pingpong_pointer_reset_bit = 1;
	localparam int resume_control_bit = 2;
	localparam int host_role_enable_bit = 3;
	localparam int bus_reset_control_bit = 4;
	localparam int token_in_progress_bit = 5;
	localparam int single_ended_zero_bit = 6;
	localparam int line_j_state_bit = 7;

	// Target address register field positions
	localparam int low_speed_select_bit = 7;
	localparam int device_address_lsb = 0;
	localparam int device_address_width = 7;

	localparam logic [5:0] host_control_reset = 6'h00;
	localparam logic [6:0] device_address_reset = 7'h00;
	localparam logic low_speed_reset = 1'b0;

	// USB line levels as sampled from the transceiver
	typedef struct packed {
		logic dplus;
		logic dminus;
	} usb_line_t;

	// Control bits leaving the register block
	typedef struct packed {
		logic bus_reset_control;
		logic host_role_enable;
		logic resume_control;
		logic pingpong_pointer_reset;
		logic frame_start_enable;
		logic low_speed_select;
		logic [6:0] device_address;
	} host_ctrl_t;
endpackage

// File: core/usb_line_state.sv
// Line state decode: J state and single-ended zero from D+ and D-.
// Assumes line inputs are already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module usb_line_state (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Line and speed
	input wire usb_host_ctrl_pkg::usb_line_t line,
	input wire logic low_speed,
	// Flags
	output logic j_state,
	output logic se0
);
	import usb_host_ctrl_pkg::*;

	typedef struct packed {
		logic j_state;
		logic se0;
	} line_state_t;

	line_state_t state_reg;
	line_state_t state_next;

	always_comb begin
		state_next = state_reg;
		// J state is differential zero at low speed, one at full speed
		if (low_speed) begin
			state_next.j_state = !line.dplus && line.dminus;
		end else begin
			state_next.j_state = line.dplus && !line.dminus;
		end
		state_next.se0 = !line.dplus && !line.dminus;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign j_state = state_reg.j_state;
	assign se0 = state_reg.se0;
endmodule // usb_line_state
`default_nettype wire

// File: core/usb_host_control_address.sv
// Host mode control and target address registers behind an APB slave.
// Assumes line inputs and token status are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Low-speed select bit set runs bus at low speed, clear at full.
// - Address register holds seven-bit device address, writable and readable.
// - Low-speed select exists only in host role, else reads zero.
// - Upper byte of address register ignores writes, reads zero.
module usb_host_control_address (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usb_host_ctrl_pkg::addr_width-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// USB line and core status
	input wire usb_host_ctrl_pkg::usb_line_t line,
	input wire logic token_in_progress,
	// Control to the USB core
	output usb_host_ctrl_pkg::host_ctrl_t ctrl
);
	import usb_host_ctrl_pkg::*;

	typedef struct packed {
		logic bus_reset_control;
		logic host_role_enable;
		logic resume_control;
		logic pingpong_pointer_reset;
		logic frame_start_enable;
		logic low_speed_select;
		logic [6:0] device_address;
		logic [31:0] rdata;
		logic slverr;
	} regs_t;

	regs_t regs_reg;
	regs_t regs_next;
	logic j_state;
	logic se0;
	logic setup_phase;
	logic access_phase;
	logic write_commit;
	logic hit_ctrl;
	logic hit_addr;
	logic hit_any;
	logic ctrl_lane;
	logic addr_lane;
	logic low_speed_eff;
	logic [15:0] ctrl_view;
	logic [15:0] addr_view;
	logic [31:0] read_word;

	// Address compare against one register offset
	function automatic logic offset_match(
		input logic [addr_width-1:0] a,
		input logic [addr_width-1:0] o);
		logic m;
		m = a == o;
		return m;
	endfunction

	// Low byte lane carries every implemented bit
	function automatic logic low_lane(input logic [3:0] s);
		logic l;
		l = s[0];
		return l;
	endfunction

	// Widen a register view to the bus word
	function automatic logic [31:0] widen(input logic [15:0] h);
		logic [31:0] w;
		w = {16'h0000, h};
		return w;
	endfunction

	function automatic logic [15:0] control_word(input regs_t r,
		input logic j, input logic z, input logic busy);
		logic [15:0] w;
		w = 16'h0000;
		w[line_j_state_bit] = j;
		w[single_ended_zero_bit] = z;
		w[token_in_progress_bit] = busy;
		w[bus_reset_control_bit] = r.bus_reset_control;
		w[host_role_enable_bit] = r.host_role_enable;
		w[resume_control_bit] = r.resume_control;
		w[pingpong_pointer_reset_bit] = r.pingpong_pointer_reset;
		w[frame_start_enable_bit] = r.frame_start_enable;
		return w;
	endfunction

	// Address register view, top byte always zero
	function automatic logic [15:0] address_word(input logic ls,
		input logic [6:0] addr);
		logic [15:0] w;
		w = 16'h0000;
		w[low_speed_select_bit] = ls;
		w[device_address_lsb +: device_address_width] = addr;
		return w;
	endfunction

	// Writable control bits; status bits are not stored
	function automatic regs_t write_control(input regs_t r,
		input logic [31:0] d);
		regs_t n;
		n = r;
		n.bus_reset_control = d[bus_reset_control_bit];
		n.host_role_enable = d[host_role_enable_bit];
		n.resume_control = d[resume_control_bit];
		n.pingpong_pointer_reset = d[pingpong_pointer_reset_bit];
		n.frame_start_enable = d[frame_start_enable_bit];
		return n;
	endfunction

	// Address and speed bits; upper byte is dropped
	function automatic regs_t write_address(input regs_t r,
		input logic [31:0] d);
		regs_t n;
		n = r;
		n.device_address = d[device_address_lsb +:
			device_address_width];
		n.low_speed_select = d[low_speed_select_bit];
		return n;
	endfunction

	// Read word for the decoded register
	function automatic logic [31:0] select_read(input logic c,
		input logic a, input logic [15:0] cv, input logic [15:0] av);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (c) begin
			w = widen(cv);
		end else if (a) begin
			w = widen(av);
		end
		return w;
	endfunction

	// Low speed only counts in host role
	assign low_speed_eff = regs_reg.low_speed_select &&
		regs_reg.host_role_enable;

	usb_line_state u_line_state (
		.pclk(pclk),
		.presetn(presetn),
		.line(line),
		.low_speed(low_speed_eff),
		.j_state(j_state),
		.se0(se0)
	);

	// Bus phases and address decode
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign write_commit = access_phase && pwrite;
	assign hit_ctrl = offset_match(paddr, host_control_offset);
	assign hit_addr = offset_match(paddr, target_address_offset);
	assign hit_any = hit_ctrl || hit_addr;
	assign ctrl_lane = hit_ctrl && low_lane(pstrb);
	assign addr_lane = hit_addr && low_lane(pstrb);

	// Register views as software reads them
	assign ctrl_view = control_word(regs_reg, j_state, se0,
		token_in_progress);
	assign addr_view = address_word(low_speed_eff,
		regs_reg.device_address);
	assign read_word = select_read(hit_ctrl, hit_addr, ctrl_view,
		addr_view);

	// Read data and error captured in setup, writes land in access
	always_comb begin
		regs_next = regs_reg;
		if (setup_phase) begin
			regs_next.slverr = !hit_any;
			regs_next.rdata = 32'h0000_0000;
			if (!pwrite) begin
				regs_next.rdata = read_word;
			end
		end
		if (write_commit && ctrl_lane) begin
			regs_next = write_control(regs_next, pwdata);
		end
		if (write_commit && addr_lane) begin
			regs_next = write_address(regs_next, pwdata);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regs_reg <= '0;
		end else begin
			regs_reg <= regs_next;
		end
	end

	// Zero wait states: read data is ready from the setup capture
	assign pready = 1'b1;
	assign prdata = regs_reg.rdata;
	assign pslverr = access_phase && regs_reg.slverr;

	always_comb begin
		ctrl.bus_reset_control = regs_reg.bus_reset_control;
		ctrl.host_role_enable = regs_reg.host_role_enable;
		ctrl.resume_control = regs_reg.resume_control;
		ctrl.pingpong_pointer_reset = regs_reg.pingpong_pointer_reset;
		ctrl.frame_start_enable = regs_reg.frame_start_enable;
		ctrl.low_speed_select = low_speed_eff;
		ctrl.device_address = regs_reg.device_address;
	end
endmodule // usb_host_control_address
`default_nettype wire

// File: verif/usb_host_ctrl_chk.sv
// Checker: register and line flag assertions.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module usb_host_ctrl_chk
	import usb_host_ctrl_pkg::*;
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// USB side
	input wire usb_host_ctrl_pkg::usb_line_t line,
	input wire usb_host_ctrl_pkg::host_ctrl_t ctrl
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence addr_wr;
		psel && penable && pwrite && pstrb[0] && paddr == target_address_offset;
	endsequence
	sequence rd_at(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	addr_hold_a: assert property (addr_wr |=>
		ctrl.device_address == $past(pwdata[6:0])) else $error("Address lost");
	speed_sel_a: assert property (addr_wr ##1 ctrl.host_role_enable |->
		ctrl.low_speed_select == $past(pwdata[7])) else $error("Speed wrong");
	host_only_a: assert property (ctrl.low_speed_select |->
		ctrl.host_role_enable) else $error("Speed without host");
	upper_zero_a: assert property (rd_at(target_address_offset) |->
		prdata[31:8] == 24'h0) else $error("Upper bits set");
	j_flag_a: assert property (rd_at(host_control_offset) |->
		prdata[7] == ($past(line.dplus, 2) ^ $past(ctrl.low_speed_select, 2)
		&& $past(line.dplus, 2) != $past(line.dminus, 2))) else $error("J wrong");
endmodule // usb_host_ctrl_chk
bind usb_host_control_address usb_host_ctrl_chk i_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.line(line), .ctrl(ctrl));
`default_nettype wire

// File: verif/usb_device_model.sv
// Partner: attached device driving J, K or idle SE0 on the lines.
// Assumes the host's chosen speed is given to it.
`timescale 1ns/1ps
`default_nettype none
module usb_device_model (
	// Line state: 0 J, 1 K, 2 SE0
	input wire logic [1:0] state,
	input wire logic low_speed,
	// Bus lines
	output usb_host_ctrl_pkg::usb_line_t line
);
	import usb_host_ctrl_pkg::*;
	assign line.dplus = state != 2'h2 && ((state == 2'h0) ^ low_speed);
	assign line.dminus = state != 2'h2 && !((state == 2'h0) ^ low_speed);
endmodule // usb_device_model
`default_nettype wire

// File: verif/usb_host_control_address_test.sv
// Testbench: APB register tests with line states from the device model.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module usb_host_control_address_test;
	import usb_host_ctrl_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tok = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] st = 2'h0;
	logic pready, pslverr, err;
	usb_line_t line;
	host_ctrl_t ctrl;
	int miscompares = 0, tests_run = 0;
	usb_host_control_address i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line(line), .token_in_progress(tok), .ctrl(ctrl));
	usb_device_model i_dev (.state(st), .low_speed(ctrl.low_speed_select),
		.line(line));
	initial forever #5 pclk = ~pclk;
	task automatic conclude;
		$display("tests %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin miscompares++; conclude; end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		xfer(0, target_address_offset, 0); `chk(rd, 32'h0)
		xfer(1, target_address_offset, 32'hffffffff);
		xfer(0, target_address_offset, 0); `chk(rd, 32'h7f)
		xfer(1, host_control_offset, 32'hff);
		@(posedge pclk);
		`chk(ctrl, 13'h1fff)
		xfer(0, target_address_offset, 0); `chk(rd, 32'hff)
		xfer(1, 12'h008, 32'h1);
		xfer(0, 12'h008, 0); `chk({err, rd}, 33'h100000000)
		$display("register test done");
		xfer(1, host_control_offset, 32'h8);
		for (int sp = 0; sp < 2; sp++) begin
			xfer(1, target_address_offset, {24'h0, sp[0], 7'h15});
			@(posedge pclk);
			`chk(ctrl.low_speed_select, sp[0])
			for (int s = 0; s < 3; s++) begin
				st <= s[1:0];
				tok <= s[0];
				xfer(0, host_control_offset, 0);
				`chk(rd, {24'h0, s == 0, s == 2, s[0], 5'h08})
			end
		end
		xfer(1, host_control_offset, 0);
		xfer(0, target_address_offset, 0); `chk(rd, 32'h15)
		$display("line state test done");
		conclude;
	end
endmodule // usb_host_control_address_test
`default_nettype wire
